// File: hdl/sss_consts.vh
// constants for the step/scan trigger sequencer
`ifndef SSS_CONSTS_VH
`define SSS_CONSTS_VH

// ******************************
// ahb register map
// ******************************
`define SSS_A_CTRL      12'h000
`define SSS_A_FIRST     12'h004
`define SSS_A_LAST      12'h008
`define SSS_A_INTERVAL  12'h00c
`define SSS_A_COUNT     12'h010
`define SSS_A_STATUS    12'h014
`define SSS_A_STORED    12'h018
`define SSS_A_RDATA     12'h01c
`define SSS_A_RINDEX    12'h020
`define SSS_A_MEAS      12'h024

// ctrl bits (step/scan/halt write 1 pulses, timer is a held enable)
`define SSS_C_STEP      0
`define SSS_C_SCAN      1
`define SSS_C_HALT      2
`define SSS_C_TIMER     3

// ******************************
// sizes and timing
// ******************************
`define SSS_CNT_MAX     11'h400
`define SSS_CNT_MIN     11'h002
`define SSS_CH_W        8
`define SSS_IDX_W       10
`define SSS_TICK_NS     10000000
`define SSS_CLK_NS      100
`define SSS_PULSE_NS    2000
`define SSS_RST_FIRST   8'h01
`define SSS_RST_LAST    8'h0a
`define SSS_RST_COUNT   11'h00a
`define SSS_HTRANS_NSEQ 2'h2

`endif

// File: hdl/sss_sequencer.v
// step/scan trigger sequencer with ahb-lite register slave
`timescale 1ns/1ns
`include "sss_consts.vh"

module sss_sequencer (
    input  wire        clk_sys,      // 10 mhz system clock
    input  wire        reset_n,      // async reset, active low
    input  wire        hsel,         // ahb slave select
    input  wire [11:0] haddr,        // ahb byte address
    input  wire [1:0]  htrans,       // ahb transfer type
    input  wire        hwrite,       // ahb write
    input  wire [2:0]  hsize,        // ahb size, word only
    input  wire        hready,       // ahb bus ready
    input  wire [31:0] hwdata,       // ahb write data
    output reg  [31:0] hrdata,       // ahb read data
    output reg         hreadyout,    // ahb slave ready
    output reg         hresp,        // ahb response, always okay
    input  wire        trigger_input_line_n, // line 2, falling edge
    output reg         measurement_done_pulse_n, // line 1, low pulse
    output reg         meas_start,   // one-cycle request to measure
    input  wire        meas_valid,   // measurement result strobe
    input  wire [31:0] meas_value,   // measurement result
    output reg  [7:0]  chan_now,     // channel being measured
    output reg         ref_chan_active // channel 1 is reference now
);

// ******************************
// timing
// ******************************
localparam integer TICK_CYC  = `SSS_TICK_NS / `SSS_CLK_NS;
localparam integer PULSE_CYC = `SSS_PULSE_NS / `SSS_CLK_NS;

localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_WAIT = 3'h1;
localparam [2:0] ST_MEAS = 3'h2;
localparam [2:0] ST_NEXT = 3'h3;

// ******************************
// registers
// ******************************
reg  [7:0]  first_r;
reg  [7:0]  last_r;
reg  [25:0] interval_r;   // 10 ms ticks, 26 bits reach 99h:99m:99.99s
reg  [10:0] count_r;
reg         timer_en_r;
reg         scan_mode_r;
reg  [2:0]  state_r;
reg  [10:0] stored_reading_count_r;
reg  [7:0]  chan_cnt_r;
reg  [25:0] tick_left_r;
reg  [16:0] tick_div_r;
reg         first_pass_r;
reg  [4:0]  pulse_cnt_r;
reg  [31:0] buf_mem [0:1023];
reg  [9:0]  rindex_r;
reg  [31:0] last_meas_r;
reg         trig_s1_r;
reg         trig_s2_r;
reg         trig_s3_r;
reg         ap_valid_r;
reg         ap_write_r;
reg  [11:0] ap_addr_r;
reg         step_go;
reg         scan_go;
reg         halt_go;

wire trig_fall = trig_s3_r & ~trig_s2_r;
wire tick      = (tick_div_r == 17'h00000);
wire timer_ok  = ~timer_en_r | first_pass_r |
                 (tick_left_r == 26'h0000000);
wire event_ok  = timer_ok & trig_fall;
wire full      = (stored_reading_count_r >= count_r);
wire ap_take   = hsel & hready & htrans[1];

// ******************************
// trigger input synchroniser
// ******************************
always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        trig_s1_r <= 1'b1;
        trig_s2_r <= 1'b1;
        trig_s3_r <= 1'b1;
    end else begin
        trig_s1_r <= trigger_input_line_n;
        trig_s2_r <= trig_s1_r;
        trig_s3_r <= trig_s2_r;
    end
end

// ******************************
// ahb slave
// ******************************
always @* begin
    step_go = 1'b0;
    scan_go = 1'b0;
    halt_go = 1'b0;
    if (ap_valid_r && ap_write_r && ap_addr_r == `SSS_A_CTRL) begin
        step_go = hwdata[`SSS_C_STEP];
        scan_go = hwdata[`SSS_C_SCAN];
        halt_go = hwdata[`SSS_C_HALT];
    end
end

always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        ap_valid_r <= 1'b0;
        ap_write_r <= 1'b0;
        ap_addr_r  <= 12'h000;
        hreadyout  <= 1'b1;
        hresp      <= 1'b0;
        hrdata     <= 32'h00000000;
        first_r    <= `SSS_RST_FIRST;
        last_r     <= `SSS_RST_LAST;
        interval_r <= 26'h0000000;
        count_r    <= `SSS_RST_COUNT;
        timer_en_r <= 1'b0;
        rindex_r   <= 10'h000;
    end else begin
        ap_valid_r <= ap_take;
        ap_write_r <= hwrite;
        ap_addr_r  <= {haddr[11:2], 2'b00};
        hreadyout  <= 1'b1;
        hresp      <= 1'b0;
        if (ap_valid_r && ap_write_r) begin
            if (ap_addr_r == `SSS_A_CTRL) begin
                timer_en_r <= hwdata[`SSS_C_TIMER];
            end else if (ap_addr_r == `SSS_A_FIRST) begin
                first_r <= hwdata[7:0];
            end else if (ap_addr_r == `SSS_A_LAST) begin
                last_r <= hwdata[7:0];
            end else if (ap_addr_r == `SSS_A_INTERVAL) begin
                interval_r <= hwdata[25:0];
            end else if (ap_addr_r == `SSS_A_COUNT) begin
                // clamp into 2..1024
                if (hwdata[10:0] > `SSS_CNT_MAX || hwdata[31:11] != 0)
                    count_r <= `SSS_CNT_MAX;
                else if (hwdata[10:0] < `SSS_CNT_MIN)
                    count_r <= `SSS_CNT_MIN;
                else
                    count_r <= hwdata[10:0];
            end else if (ap_addr_r == `SSS_A_RINDEX) begin
                rindex_r <= hwdata[9:0];
            end
        end
        // read data is prepared in the address phase
        if (ap_take && !hwrite) begin
            if ({haddr[11:2], 2'b00} == `SSS_A_CTRL)
                hrdata <= {28'h0, timer_en_r, 3'b000};
            else if ({haddr[11:2], 2'b00} == `SSS_A_FIRST)
                hrdata <= {24'h0, first_r};
            else if ({haddr[11:2], 2'b00} == `SSS_A_LAST)
                hrdata <= {24'h0, last_r};
            else if ({haddr[11:2], 2'b00} == `SSS_A_INTERVAL)
                hrdata <= {6'h00, interval_r};
            else if ({haddr[11:2], 2'b00} == `SSS_A_COUNT)
                hrdata <= {21'h0, count_r};
            else if ({haddr[11:2], 2'b00} == `SSS_A_STATUS)
                hrdata <= {24'h0, ref_chan_active, full, scan_mode_r,
                           2'b00, state_r};
            else if ({haddr[11:2], 2'b00} == `SSS_A_STORED)
                hrdata <= {21'h0, stored_reading_count_r};
            else if ({haddr[11:2], 2'b00} == `SSS_A_RDATA)
                hrdata <= buf_mem[rindex_r];
            else if ({haddr[11:2], 2'b00} == `SSS_A_RINDEX)
                hrdata <= {22'h0, rindex_r};
            else if ({haddr[11:2], 2'b00} == `SSS_A_MEAS)
                hrdata <= last_meas_r;
            else
                hrdata <= 32'h00000000;
        end
    end
end

// ******************************
// reading buffer
// ******************************
// no reset on the array: contents are volatile and overwritten per run
always @(posedge clk_sys) begin
    if (state_r == ST_MEAS && meas_valid && !full)
        buf_mem[stored_reading_count_r[9:0]] <= meas_value;
end

// ******************************
// interval timer, 10 ms ticks
// ******************************
always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        tick_div_r  <= 17'h00000;
        tick_left_r <= 26'h0000000;
    end else begin
        // free-running divider: the first tick of an interval may be short
        if (tick)
            tick_div_r <= TICK_CYC[16:0] - 17'h00001;
        else
            tick_div_r <= tick_div_r - 17'h00001;
        // reload when an event passes; count down otherwise
        if (state_r == ST_WAIT && event_ok)
            tick_left_r <= interval_r;
        else if (tick && tick_left_r != 26'h0000000)
            tick_left_r <= tick_left_r - 26'h0000001;
    end
end

// ******************************
// sequencer
// ******************************
always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        state_r                  <= ST_IDLE;
        scan_mode_r              <= 1'b0;
        stored_reading_count_r   <= 11'h000;
        chan_cnt_r               <= 8'h00;
        first_pass_r             <= 1'b0;
        pulse_cnt_r              <= 5'h00;
        measurement_done_pulse_n <= 1'b1;
        meas_start               <= 1'b0;
        chan_now                 <= 8'h00;
        ref_chan_active          <= 1'b0;
        last_meas_r              <= 32'h00000000;
    end else begin
        meas_start <= 1'b0;
        if (meas_valid)
            last_meas_r <= meas_value;
        // done pulse on line 1, fixed low width
        if (pulse_cnt_r != 5'h00) begin
            pulse_cnt_r <= pulse_cnt_r - 5'h01;
            measurement_done_pulse_n <= (pulse_cnt_r == 5'h01);
        end
        // the reference flag moves with chan_now so it never lags a step
        if (halt_go) begin
            state_r         <= ST_IDLE;
            scan_mode_r     <= 1'b0;
            ref_chan_active <= 1'b0;
        end else begin
            case (state_r)
            ST_IDLE: begin
                if (step_go || scan_go) begin
                    scan_mode_r            <= scan_go & ~step_go;
                    stored_reading_count_r <= 11'h000;
                    chan_now               <= first_r;
                    ref_chan_active        <= (first_r == 8'h01);
                    chan_cnt_r             <= last_r - first_r;
                    first_pass_r           <= 1'b1;
                    state_r                <= ST_WAIT;
                end
            end
            ST_WAIT: begin
                // the partner closes a channel, then triggers
                if (event_ok) begin
                    first_pass_r <= 1'b0;
                    meas_start   <= 1'b1;
                    state_r      <= ST_MEAS;
                end
            end
            ST_MEAS: begin
                if (meas_valid) begin
                    if (!full)
                        stored_reading_count_r <=
                            stored_reading_count_r + 11'h001;
                    state_r <= ST_NEXT;
                end
            end
            default: begin
                // scan pulses only at list end, step after every one
                if (!scan_mode_r || chan_cnt_r == 8'h00) begin
                    pulse_cnt_r <= PULSE_CYC[4:0];
                    measurement_done_pulse_n <= 1'b0;
                end
                if (full) begin
                    state_r         <= ST_IDLE;
                    scan_mode_r     <= 1'b0;
                    ref_chan_active <= 1'b0;
                end else if (scan_mode_r && chan_cnt_r != 8'h00) begin
                    // inside the list: no event wait
                    chan_cnt_r      <= chan_cnt_r - 8'h01;
                    chan_now        <= chan_now + 8'h01;
                    ref_chan_active <= (chan_now == 8'h00);
                    meas_start      <= 1'b1;
                    state_r         <= ST_MEAS;
                end else begin
                    chan_cnt_r <= last_r - first_r;
                    if (!scan_mode_r && chan_now != last_r) begin
                        chan_now        <= chan_now + 8'h01;
                        ref_chan_active <= (chan_now == 8'h00);
                    end else begin
                        chan_now        <= first_r;
                        ref_chan_active <= (first_r == 8'h01);
                    end
                    state_r <= ST_WAIT;
                end
            end
            endcase
        end
    end
end

endmodule

// File: bench/sss_chk.sv
// port checker for the step/scan trigger sequencer
`timescale 1ns/1ns
module sss_chk (
    input wire       clk_sys,                  // clock
    input wire       reset_n,                  // async reset
    input wire       hreadyout,                // slave ready
    input wire       hresp,                    // response
    input wire       measurement_done_pulse_n, // line 1
    input wire       meas_start,               // measure request
    input wire       meas_valid,               // result strobe
    input wire [7:0] chan_now,                 // channel
    input wire       ref_chan_active           // reference flag
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    reg [5:0] lo_cnt;
    // ********************
    // done pulse length; saturates so a stuck line still fails
    // ********************
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) lo_cnt <= 6'h00;
        else if (measurement_done_pulse_n) lo_cnt <= 6'h00;
        else if (lo_cnt != 6'h3f) lo_cnt <= lo_cnt + 6'h01;
    end
    a_done_width: assert property (
        $rose(measurement_done_pulse_n) |-> lo_cnt == 6'h14)
        else $error("done pulse not 20 cycles");
    a_done_cap: assert property (lo_cnt <= 6'h14)
        else $error("done pulse too long");
    a_done_cause: assert property (
        $fell(measurement_done_pulse_n) |-> $past(meas_valid, 2))
        else $error("done pulse without result");
    a_start_single: assert property (meas_start |=> !meas_start)
        else $error("measure request longer than one cycle");
    a_chan_hold: assert property (
        meas_start |=> $stable(chan_now) [*2])
        else $error("channel moved during measurement");
    a_ref_chan: assert property (
        ref_chan_active |-> chan_now == 8'h01)
        else $error("reference flag off channel 1");
    a_bus_ready: assert property (hreadyout)
        else $error("slave inserted wait");
    a_bus_okay: assert property (!hresp)
        else $error("response not okay");
    c_pulse: cover property ($rose(measurement_done_pulse_n));
    c_ref: cover property (ref_chan_active);
    c_start: cover property (meas_start);
endmodule
bind sss_sequencer sss_chk i_sss_chk (.clk_sys(clk_sys),
    .reset_n(reset_n), .hreadyout(hreadyout), .hresp(hresp),
    .measurement_done_pulse_n(measurement_done_pulse_n),
    .meas_start(meas_start), .meas_valid(meas_valid),
    .chan_now(chan_now), .ref_chan_active(ref_chan_active));

// File: bench/sss_mainframe.sv
// model of the external switching mainframe on the trigger lines
`timescale 1ns/1ns
module sss_mainframe (
    input  wire       clk_sys, // clock
    input  wire       reset_n, // async reset
    input  wire       go,      // start channel closures
    input  wire       done_n,  // done pulse from the meter
    output reg        trig_n,  // reading request to the meter
    output reg  [7:0] dones    // done pulses seen
);
    reg [4:0] t_r;
    reg       done_q;
    // ********************
    // close next channel after each pulse; delay stands for settling
    // ********************
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            trig_n <= 1'b1;
            t_r    <= 5'h00;
            dones  <= 8'h00;
            done_q <= 1'b1;
        end else begin
            done_q <= done_n;
            if (done_n && !done_q) dones <= dones + 8'h01;
            if (go || (done_n && !done_q)) t_r <= 5'h0f;
            else if (t_r != 5'h00) t_r <= t_r - 5'h01;
            trig_n <= (t_r == 5'h00) || (t_r > 5'h05);
        end
    end
endmodule

// File: bench/sss_sequencer_tb.sv
// self-checking bench for the step/scan trigger sequencer
`timescale 1ns/1ns
`include "sss_consts.vh"
module sss_sequencer_tb;
    reg         clk_sys = 1'b0;
    reg         reset_n = 1'b0;
    reg         hsel = 1'b0;
    reg  [11:0] haddr = 12'h000;
    reg  [1:0]  htrans = 2'h0;
    reg         hwrite = 1'b0;
    reg  [31:0] hwdata = 32'h0;
    reg         go = 1'b0;
    reg         meas_valid = 1'b0;
    reg  [31:0] meas_value = 32'h0;
    reg  [2:0]  pipe = 3'h0;
    reg  [31:0] n_meas = 32'h0;
    reg  [31:0] m0, rd;
    reg  [7:0]  d0;
    wire [31:0] hrdata;
    wire [7:0]  chan_now, dones;
    wire        hreadyout, hresp, trig_n, done_n, meas_start, ref_act;
    integer     mismatches = 0;
    integer     check_count = 0;
    always #50 clk_sys = ~clk_sys;
    sss_sequencer i_sss_sequencer (.clk_sys(clk_sys), .reset_n(reset_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .trigger_input_line_n(trig_n), .measurement_done_pulse_n(done_n),
        .meas_start(meas_start), .meas_valid(meas_valid),
        .meas_value(meas_value), .chan_now(chan_now),
        .ref_chan_active(ref_act));
    sss_mainframe i_sss_mainframe (.clk_sys(clk_sys), .reset_n(reset_n),
        .go(go), .done_n(done_n), .trig_n(trig_n), .dones(dones));
    // ********************
    // measurement engine: result four cycles after each request
    // ********************
    always @(posedge clk_sys) begin
        pipe <= {pipe[1:0], meas_start};
        meas_valid <= pipe[2];
        if (pipe[2]) begin
            meas_value <= 32'ha000 + n_meas;
            n_meas <= n_meas + 32'h1;
        end
    end
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("BAD %0t seen %h want %h", $time, seen, exp);
            end
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", check_count, mismatches);
            if (mismatches == 0 && check_count > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    task wait_rdy;
        integer n;
        begin
            n = 0;
            @(posedge clk_sys);
            while (hreadyout !== 1'b1 && n < 50) begin
                @(posedge clk_sys);
                n = n + 1;
            end
            if (n >= 50) begin
                chk(32'h0, 32'h1);
                stop_test;
            end
        end
    endtask
    task xfer(input w, input [11:0] a, input [31:0] d);
        begin
            hsel <= 1'b1;
            htrans <= `SSS_HTRANS_NSEQ;
            haddr <= a;
            hwrite <= w;
            wait_rdy;
            htrans <= 2'h0;
            hwdata <= d;
            wait_rdy;
            rd = hrdata;
        end
    endtask
    task rg(input [11:0] a, input [31:0] exp);
        begin
            xfer(1'b0, a, 32'h0);
            chk(rd, exp);
        end
    endtask
    task kick;
        begin
            go <= 1'b1;
            @(posedge clk_sys);
            go <= 1'b0;
        end
    endtask
    task setup(input [7:0] f, input [7:0] l, input [10:0] c,
               input [31:0] ctl);
        begin
            xfer(1'b1, `SSS_A_FIRST, {24'h0, f});
            xfer(1'b1, `SSS_A_LAST, {24'h0, l});
            xfer(1'b1, `SSS_A_COUNT, {21'h0, c});
            xfer(1'b1, `SSS_A_CTRL, ctl);
            d0 = dones;
            m0 = n_meas;
            kick;
        end
    endtask
    // polls status; the extra wait lets the last pulse and retrigger pass
    task wait_idle;
        integer n;
        begin
            n = 0;
            rd = 32'h1;
            while (rd[2:0] !== 3'h0 && n < 300) begin
                xfer(1'b0, `SSS_A_STATUS, 32'h0);
                n = n + 1;
            end
            if (n >= 300) begin
                chk(32'h0, 32'h1);
                stop_test;
            end
            repeat (60) @(posedge clk_sys);
        end
    endtask
    task t_reset;
        begin
            rg(`SSS_A_FIRST, {24'h0, `SSS_RST_FIRST});
            rg(`SSS_A_LAST, {24'h0, `SSS_RST_LAST});
            rg(`SSS_A_COUNT, {21'h0, `SSS_RST_COUNT});
            rg(`SSS_A_INTERVAL, 32'h0);
            xfer(1'b1, `SSS_A_STATUS, 32'hff);
            rg(`SSS_A_STATUS, 32'h0);
            rg(12'h0fc, 32'h0);
        end
    endtask
    task t_clamp;
        begin
            xfer(1'b1, `SSS_A_COUNT, 32'h1);
            rg(`SSS_A_COUNT, {21'h0, `SSS_CNT_MIN});
            xfer(1'b1, `SSS_A_COUNT, 32'h7ff);
            rg(`SSS_A_COUNT, {21'h0, `SSS_CNT_MAX});
            xfer(1'b1, `SSS_A_INTERVAL, 32'hffffffff);
            rg(`SSS_A_INTERVAL, 32'h3ffffff);
        end
    endtask
    task t_step;
        integer i;
        begin
            xfer(1'b1, `SSS_A_INTERVAL, 32'h0);
            setup(8'h01, 8'h03, 11'h003, 32'h1);
            wait_idle;
            chk({24'h0, dones - d0}, 32'h3);
            chk(n_meas - m0, 32'h3);
            rg(`SSS_A_STORED, 32'h3);
            for (i = 0; i < 3; i = i + 1) begin
                xfer(1'b1, `SSS_A_RINDEX, i);
                rg(`SSS_A_RDATA, 32'ha000 + m0 + i);
            end
        end
    endtask
    // count below two full lists: the second list stops early, and only
    // the list that reached its last channel gives a done pulse
    task t_scan;
        begin
            setup(8'h02, 8'h05, 11'h006, 32'h2);
            wait_idle;
            chk(rd, 32'h40);
            chk({24'h0, dones - d0}, 32'h1);
            chk(n_meas - m0, 32'h6);
            rg(`SSS_A_STORED, 32'h6);
            rg(`SSS_A_MEAS, 32'ha005 + m0);
        end
    endtask
    task t_timer;
        begin
            xfer(1'b1, `SSS_A_INTERVAL, 32'h1);
            setup(8'h01, 8'h03, 11'h00a, 32'h9);
            chk({24'h0, chan_now}, 32'h1);
            chk({31'h0, ref_act}, 32'h1);
            repeat (150) @(posedge clk_sys);
            chk(n_meas - m0, 32'h1);
            chk({24'h0, chan_now}, 32'h2);
            rg(`SSS_A_STATUS, 32'h1);
            xfer(1'b1, `SSS_A_CTRL, 32'h4);
            rg(`SSS_A_STATUS, 32'h0);
            kick;
            repeat (60) @(posedge clk_sys);
            chk(n_meas - m0, 32'h1);
            chk({31'h0, ref_act}, 32'h0);
        end
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        t_reset;
        t_clamp;
        t_step;
        t_scan;
        t_timer;
        stop_test;
    end
endmodule
